// >>> core/smso_pkg.sv
// constants, field widths and mode codes shared by the mode switch and status output block
//--------------------------------------------------------------------------------
// How it works
// R1 - selections 7, 8, 9 map switch to modes
// R2 - fixed assignment reads dedicated mode-switch pin
// R3 - configurable assignment reads selected input pin
// R4 - selection 10 fixed: switch gives zero clamp
// R5 - selection 11 fixed: switch inhibits command pulses
// R6 - configurable: clamp and inhibit inputs steer 10, 11
// R7 - clamping also needs both zero-clamp parameters
// R8 - ready needs power, no block, no alarm
// R9 - output slot one defaults to ready code
// R10 - warning drives only slots coded 0x07/0x107
// R11 - code 0x107 drives warning inverted
// R12 - warning output follows pre-alarm warning condition
// R13 - host waits over 100ms before motion commands; the host model waits 20 clock cycles
// R14 - inputs synchronised; mode follows next cycle; the block updates mode on the third clock after a pin change
//--------------------------------------------------------------------------------
package smso_pkg;

    //--------------------------------------------------------------------------------
    // widths
    //--------------------------------------------------------------------------------
    localparam int SMSO_SEQ_IN_W   = 8;
    localparam int SMSO_PIN_SEL_W  = 3;
    localparam int SMSO_MODE_SEL_W = 5;
    localparam int SMSO_OUT_CODE_W = 9;
    localparam int SMSO_OUT_COUNT  = 3;
    localparam int SMSO_ZC_MODE_W  = 4;
    localparam int SMSO_SPEED_W    = 16;
    localparam int SMSO_SYNC_W     = SMSO_SEQ_IN_W + 6;

    //--------------------------------------------------------------------------------
    // positions of the pin inputs inside the synchroniser word
    //--------------------------------------------------------------------------------
    localparam int SMSO_BIT_FIXED   = SMSO_SEQ_IN_W;
    localparam int SMSO_BIT_POWER   = SMSO_SEQ_IN_W + 1;
    localparam int SMSO_BIT_BBLOCK  = SMSO_SEQ_IN_W + 2;
    localparam int SMSO_BIT_ALARM   = SMSO_SEQ_IN_W + 3;
    localparam int SMSO_BIT_WARN    = SMSO_SEQ_IN_W + 4;
    localparam int SMSO_BIT_ABSREQ  = SMSO_SEQ_IN_W + 5;

    //--------------------------------------------------------------------------------
    // control mode selection values
    //--------------------------------------------------------------------------------
    localparam logic [SMSO_MODE_SEL_W-1:0] SMSO_SEL_SPD_POS  = 5'h07;
    localparam logic [SMSO_MODE_SEL_W-1:0] SMSO_SEL_TRQ_POS  = 5'h08;
    localparam logic [SMSO_MODE_SEL_W-1:0] SMSO_SEL_SPD_TRQ  = 5'h09;
    localparam logic [SMSO_MODE_SEL_W-1:0] SMSO_SEL_SPD_ZC   = 5'h0A;
    localparam logic [SMSO_MODE_SEL_W-1:0] SMSO_SEL_POS_INH  = 5'h0B;

    localparam logic SMSO_ASSIGN_FIXED = 1'h0;
    localparam logic SMSO_ASSIGN_PARAM = 1'h1;

    //--------------------------------------------------------------------------------
    // output assignment codes and factory defaults
    //--------------------------------------------------------------------------------
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_CODE_READY    = 9'h000;
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_CODE_WARN     = 9'h007;
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_CODE_WARN_INV = 9'h107;
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_CODE_UNUSED   = 9'h0FF;
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_DEFAULT_OUT_1 = SMSO_CODE_READY;
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_DEFAULT_OUT_2 = SMSO_CODE_UNUSED;
    localparam logic [SMSO_OUT_CODE_W-1:0] SMSO_DEFAULT_OUT_3 = SMSO_CODE_UNUSED;

    localparam logic [SMSO_ZC_MODE_W-1:0] SMSO_ZC_DISABLED = 4'h0;

    //--------------------------------------------------------------------------------
    // active loop mode
    //--------------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SMSO_MODE_POSITION = 3'b000,
        SMSO_MODE_SPEED    = 3'b001,
        SMSO_MODE_TORQUE   = 3'b010,
        SMSO_MODE_SPEED_ZC = 3'b011,
        SMSO_MODE_POS_INH  = 3'b100,
        SMSO_MODE_OTHER    = 3'b111
    } smso_mode_t;

endpackage : smso_pkg

// >>> core/smso_sync.sv
// two-flop synchroniser for the sequence and status pin inputs
`timescale 1ns/1ps
module smso_sync
    import smso_pkg::*;
#(
    parameter int W = SMSO_SYNC_W
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } smso_sync_t;

    smso_sync_t st;
    smso_sync_t next_st;

    // first stage feeds only the second stage
    always_comb
    begin
        next_st        = st;
        next_st.meta   = din;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dout = st.stable;

endmodule : smso_sync

// >>> core/smso_out_map.sv
// one configurable output slot: picks ready or warning by assignment code
`timescale 1ns/1ps
module smso_out_map
    import smso_pkg::*;
(
    input  wire logic [SMSO_OUT_CODE_W-1:0] code,
    input  wire logic                       servo_ready,
    input  wire logic                       warning,
    output logic                            level
);

    always_comb
    begin
        if (code == SMSO_CODE_READY)
        begin
            level = servo_ready;                  // R9
        end
        else if (code == SMSO_CODE_WARN)
        begin
            level = warning;                      // R10
        end
        else if (code == SMSO_CODE_WARN_INV)
        begin
            level = ~warning;                     // R11
        end
        else
        begin
            // unassigned codes keep the slot quiet rather than floating
            level = 1'b0;                         // R10
        end
    end

endmodule : smso_out_map

// >>> core/smso_mode_status.sv
// control mode selection, servo ready and configurable status outputs of the drive
`timescale 1ns/1ps
module smso_mode_status
    import smso_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic [SMSO_SEQ_IN_W-1:0]   seq_input,
    input  wire logic                       mode_switch_fixed,
    input  wire logic                       main_power_ok,
    input  wire logic                       hw_base_block,
    input  wire logic                       alarm_active,
    input  wire logic                       warning_active,
    input  wire logic                       absolute_data_request,
    input  wire logic [SMSO_MODE_SEL_W-1:0] control_mode_selection,
    input  wire logic                       input_assignment_mode,
    input  wire logic [SMSO_PIN_SEL_W-1:0]  mode_switch_pin_sel,
    input  wire logic [SMSO_PIN_SEL_W-1:0]  zero_clamp_pin_sel,
    input  wire logic [SMSO_PIN_SEL_W-1:0]  pulse_inhibit_pin_sel,
    input  wire logic [SMSO_ZC_MODE_W-1:0]  zero_clamp_param_a,
    input  wire logic [SMSO_SPEED_W-1:0]    zero_clamp_param_b,
    input  wire logic [SMSO_SPEED_W-1:0]    speed_command_abs,
    input  wire logic                       absolute_encoder_used,
    input  wire logic [SMSO_OUT_CODE_W-1:0] output_assignment_1,
    input  wire logic [SMSO_OUT_CODE_W-1:0] output_assignment_2,
    input  wire logic [SMSO_OUT_CODE_W-1:0] output_assignment_3,
    output logic [2:0]                      active_mode,
    output logic                            zero_clamp_active,
    output logic                            pulse_inhibit_active,
    output logic                            servo_ready,
    output logic                            warning_out,
    output logic [SMSO_OUT_COUNT-1:0]       out_pin
);

    //--------------------------------------------------------------------------------
    // input synchronisation
    //--------------------------------------------------------------------------------
    logic [SMSO_SYNC_W-1:0] pins_raw;
    logic [SMSO_SYNC_W-1:0] pins;

    assign pins_raw = {absolute_data_request, warning_active, alarm_active,
                       hw_base_block, main_power_ok, mode_switch_fixed, seq_input};

    // pins cross from the outside world, so nothing reads them before two flops
    smso_sync #(
        .W    (SMSO_SYNC_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (pins_raw),
        .dout    (pins)
    );                                            // R14

    logic [SMSO_SEQ_IN_W-1:0] s_seq;
    logic                     s_fixed;
    logic                     s_power;
    logic                     s_bblock;
    logic                     s_alarm;
    logic                     s_warn;
    logic                     s_absreq;

    assign s_seq    = pins[SMSO_SEQ_IN_W-1:0];
    assign s_fixed  = pins[SMSO_BIT_FIXED];
    assign s_power  = pins[SMSO_BIT_POWER];
    assign s_bblock = pins[SMSO_BIT_BBLOCK];
    assign s_alarm  = pins[SMSO_BIT_ALARM];
    assign s_warn   = pins[SMSO_BIT_WARN];
    assign s_absreq = pins[SMSO_BIT_ABSREQ];

    //--------------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------------
    typedef struct packed {
        smso_mode_t                mode;
        logic                      zero_clamp_input;
        logic                      inhibit;
        logic                      ready;
        logic                      warn;
        logic [SMSO_OUT_COUNT-1:0] pin;
    } smso_state_t;

    smso_state_t st;
    smso_state_t next_st;

    //--------------------------------------------------------------------------------
    // output slot mapping
    //--------------------------------------------------------------------------------
    logic [SMSO_OUT_CODE_W-1:0] slot_code [SMSO_OUT_COUNT];
    logic [SMSO_OUT_COUNT-1:0]  slot_level;

    assign slot_code[0] = output_assignment_1;
    assign slot_code[1] = output_assignment_2;
    assign slot_code[2] = output_assignment_3;

    genvar g;
    generate
        for (g = 0; g < SMSO_OUT_COUNT; g++)
        begin : g_slot
            smso_out_map u_map (
                .code        (slot_code[g]),
                .servo_ready (st.ready),
                .warning     (st.warn),
                .level       (slot_level[g])
            );
        end
    endgenerate

    //--------------------------------------------------------------------------------
    // mode source selection and decode
    //--------------------------------------------------------------------------------
    logic sw_in;
    logic zc_in;
    logic inh_in;

    always_comb
    begin
        if (input_assignment_mode == SMSO_ASSIGN_FIXED)
        begin
            // one dedicated pin serves the switch, clamp and inhibit roles
            sw_in  = s_fixed;                     // R2
            zc_in  = s_fixed;                     // R4
            inh_in = s_fixed;                     // R5
        end
        else
        begin
            sw_in  = s_seq[mode_switch_pin_sel];  // R3
            zc_in  = s_seq[zero_clamp_pin_sel];   // R6
            inh_in = s_seq[pulse_inhibit_pin_sel];// R6
        end
    end

    always_comb
    begin
        next_st = st;
        case (control_mode_selection)
            SMSO_SEL_SPD_POS: next_st.mode = sw_in ? SMSO_MODE_SPEED : SMSO_MODE_POSITION;      // R1
            SMSO_SEL_TRQ_POS: next_st.mode = sw_in ? SMSO_MODE_TORQUE : SMSO_MODE_POSITION;     // R1
            SMSO_SEL_SPD_TRQ: next_st.mode = sw_in ? SMSO_MODE_SPEED : SMSO_MODE_TORQUE;        // R1
            SMSO_SEL_SPD_ZC:  next_st.mode = zc_in ? SMSO_MODE_SPEED_ZC : SMSO_MODE_SPEED;      // R4
            SMSO_SEL_POS_INH: next_st.mode = inh_in ? SMSO_MODE_POS_INH : SMSO_MODE_POSITION;   // R5
            // other selections belong to logic outside this block
            default:          next_st.mode = SMSO_MODE_OTHER;
        endcase

        // the clamp request only arms clamping; the parameters decide when it bites
        next_st.zero_clamp_input  = (next_st.mode == SMSO_MODE_SPEED_ZC)
                          && (zero_clamp_param_a != SMSO_ZC_DISABLED)
                          && (speed_command_abs < zero_clamp_param_b);                          // R7
        next_st.inhibit = (next_st.mode == SMSO_MODE_POS_INH);                                  // R5

        next_st.ready = s_power && !s_bblock && !s_alarm
                        && (!absolute_encoder_used || s_absreq);                                // R8
        next_st.warn  = s_warn;                                                                 // R12
        // slots follow registered status, one cycle behind it
        next_st.pin   = slot_level;                                                             // R10
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st <= '{mode: SMSO_MODE_OTHER, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign active_mode          = st.mode;
    assign zero_clamp_active    = st.zero_clamp_input;
    assign pulse_inhibit_active = st.inhibit;
    assign servo_ready          = st.ready;
    assign warning_out          = st.warn;
    assign out_pin              = st.pin;

    //--------------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------------
    mode_seven_a : assert property (@(posedge clk_sys) disable iff (rst)   // R1
        control_mode_selection == SMSO_SEL_SPD_POS
        |=> st.mode == ($past(sw_in) ? SMSO_MODE_SPEED : SMSO_MODE_POSITION))
        else $error("mode 7 decode wrong");

    mode_nine_a : assert property (@(posedge clk_sys) disable iff (rst)   // R1
        control_mode_selection == SMSO_SEL_SPD_TRQ && !sw_in |=> st.mode == SMSO_MODE_TORQUE)
        else $error("mode 9 off decode wrong");

    fixed_source_a : assert property (@(posedge clk_sys) disable iff (rst)   // R2
        input_assignment_mode == SMSO_ASSIGN_FIXED && control_mode_selection == SMSO_SEL_TRQ_POS
        && $stable(control_mode_selection) && $stable(input_assignment_mode)
        |=> (st.mode == SMSO_MODE_TORQUE) == $past(mode_switch_fixed, 3))
        else $error("fixed pin not steering mode");

    param_source_a : assert property (@(posedge clk_sys) disable iff (rst)   // R3
        input_assignment_mode == SMSO_ASSIGN_PARAM && control_mode_selection == SMSO_SEL_SPD_POS
        |=> (st.mode == SMSO_MODE_SPEED) == $past(s_seq[mode_switch_pin_sel]))
        else $error("assigned pin not steering mode");

    zero_clamp_input_mode_a : assert property (@(posedge clk_sys) disable iff (rst)   // R4
        control_mode_selection == SMSO_SEL_SPD_ZC && zc_in |=> st.mode == SMSO_MODE_SPEED_ZC)
        else $error("zero clamp mode missing");

    inhibit_mode_a : assert property (@(posedge clk_sys) disable iff (rst)   // R6
        control_mode_selection == SMSO_SEL_POS_INH
        |=> st.inhibit == $past(inh_in) && st.mode != SMSO_MODE_SPEED)
        else $error("pulse inhibit wrong");

    zero_clamp_input_gate_a : assert property (@(posedge clk_sys) disable iff (rst)   // R7
        st.zero_clamp_input |-> st.mode == SMSO_MODE_SPEED_ZC
        && $past(zero_clamp_param_a) != SMSO_ZC_DISABLED
        && $past(speed_command_abs) < $past(zero_clamp_param_b))
        else $error("clamp without parameters");

    ready_cond_a : assert property (@(posedge clk_sys) disable iff (rst)   // R8
        st.ready |-> $past(s_power) && !$past(s_bblock) && !$past(s_alarm)
        && (!$past(absolute_encoder_used) || $past(s_absreq)))
        else $error("ready without permission");

    ready_slot_a : assert property (@(posedge clk_sys) disable iff (rst)   // R9
        output_assignment_1 == SMSO_CODE_READY |=> st.pin[0] == $past(st.ready))
        else $error("slot one not showing ready");

    warn_polarity_a : assert property (@(posedge clk_sys) disable iff (rst)   // R11
        output_assignment_1 == SMSO_CODE_WARN_INV |=> st.pin[0] == !$past(st.warn))
        else $error("inverted warning wrong");

    warn_unassigned_a : assert property (@(posedge clk_sys) disable iff (rst)   // R10
        output_assignment_3 != SMSO_CODE_READY && output_assignment_3 != SMSO_CODE_WARN
        && output_assignment_3 != SMSO_CODE_WARN_INV |=> !st.pin[2])
        else $error("unassigned slot driven");

    warn_follow_a : assert property (@(posedge clk_sys) disable iff (rst)   // R12
        $rose(warning_active) ##1 warning_active ##1 warning_active |=> st.warn)
        else $error("warning not forwarded");

    sync_delay_a : assert property (@(posedge clk_sys) disable iff (rst)   // R14
        $rose(alarm_active) ##1 alarm_active |-> ##2 !st.ready)
        else $error("alarm did not drop ready in time");

endmodule : smso_mode_status

// >>> verification/smso_host_model.sv
// host controller model: drives the sequence pins and holds motion back after ready
`timescale 1ns/1ps
module smso_host_model
    import smso_pkg::*;
#(
    parameter int HOLD_OFF = 20
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     servo_ready,
    output logic      [SMSO_SEQ_IN_W-1:0] seq_input,
    output logic                          mode_switch_fixed,
    output logic                          motion_ok
);
    int unsigned wait_cnt;

    initial
    begin
        seq_input = 8'h00;
        mode_switch_fixed = 1'b0;
    end

    // pins move on the falling edge, well away from the drive's sampling edge
    task automatic put_pins(input logic [SMSO_SEQ_IN_W-1:0] pins, input logic fixed_pin);
        @(negedge clk_sys);
        seq_input = pins;
        mode_switch_fixed = fixed_pin;
    endtask : put_pins

    // brake needs time to release; shortened count keeps the run brief
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst || !servo_ready)
        begin
            wait_cnt  <= 0;
            motion_ok <= 1'b0;
        end
        else
        begin
            wait_cnt  <= (wait_cnt < HOLD_OFF) ? wait_cnt + 1 : wait_cnt;
            motion_ok <= (wait_cnt >= HOLD_OFF);
        end
    end
endmodule : smso_host_model

// >>> verification/smso_mode_status_tb_top.sv
// self-checking testbench of the mode selection and status output block
`timescale 1ns/1ps
module smso_mode_status_tb_top
    import smso_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [SMSO_SEQ_IN_W-1:0]   seq_input;
    logic                       mode_switch_fixed, motion_ok, input_assignment_mode, absolute_encoder_used;
    logic                       main_power_ok, hw_base_block, alarm_active, warning_active, absolute_data_request;
    logic [SMSO_MODE_SEL_W-1:0] control_mode_selection;
    logic [SMSO_PIN_SEL_W-1:0]  mode_switch_pin_sel, zero_clamp_pin_sel, pulse_inhibit_pin_sel;
    logic [SMSO_ZC_MODE_W-1:0]  zero_clamp_param_a;
    logic [SMSO_SPEED_W-1:0]    zero_clamp_param_b, speed_command_abs;
    logic [SMSO_OUT_CODE_W-1:0] output_assignment_1, output_assignment_2, output_assignment_3;
    logic [2:0]                 active_mode;
    logic                       zero_clamp_active, pulse_inhibit_active, servo_ready, warning_out;
    logic [SMSO_OUT_COUNT-1:0]  out_pin;
    int                         n_mismatch = 0;
    int                         compares = 0;

    always #5 clk_sys = ~clk_sys;

    smso_host_model #(.HOLD_OFF(20)) smso_host_model_i (.clk_sys(clk_sys), .rst(rst), .servo_ready(servo_ready),
        .seq_input(seq_input), .mode_switch_fixed(mode_switch_fixed), .motion_ok(motion_ok));

    smso_mode_status smso_mode_status_i (.clk_sys(clk_sys), .rst(rst), .seq_input(seq_input),
        .mode_switch_fixed(mode_switch_fixed), .main_power_ok(main_power_ok), .hw_base_block(hw_base_block),
        .alarm_active(alarm_active), .warning_active(warning_active), .absolute_data_request(absolute_data_request),
        .control_mode_selection(control_mode_selection), .input_assignment_mode(input_assignment_mode),
        .mode_switch_pin_sel(mode_switch_pin_sel), .zero_clamp_pin_sel(zero_clamp_pin_sel),
        .pulse_inhibit_pin_sel(pulse_inhibit_pin_sel), .zero_clamp_param_a(zero_clamp_param_a),
        .zero_clamp_param_b(zero_clamp_param_b), .speed_command_abs(speed_command_abs),
        .absolute_encoder_used(absolute_encoder_used), .output_assignment_1(output_assignment_1),
        .output_assignment_2(output_assignment_2), .output_assignment_3(output_assignment_3),
        .active_mode(active_mode), .zero_clamp_active(zero_clamp_active),
        .pulse_inhibit_active(pulse_inhibit_active), .servo_ready(servo_ready), .warning_out(warning_out),
        .out_pin(out_pin));

    //--------------------------------------------------------------------------------
    // shared tasks
    //--------------------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // pins cross two sync flops, then the mode flop, then the slot flop
    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask : settle

    task automatic pins(input logic [7:0] p, input logic f);
        smso_host_model_i.put_pins(p, f);
        settle();
    endtask : pins

    task automatic set_cfg(input logic [4:0] sel, input logic asg);
        @(negedge clk_sys);
        control_mode_selection = sel;
        input_assignment_mode = asg;
    endtask : set_cfg

    task automatic mode_is(input logic [2:0] m, input logic zc, input logic inh);
        check("active_mode", 16'(active_mode), 16'(m));
        check("zero_clamp_active", 16'(zero_clamp_active), 16'(zc));
        check("pulse_inhibit_active", 16'(pulse_inhibit_active), 16'(inh));
    endtask : mode_is

    // assigned mode raises only the selected pin, fixed mode only the dedicated pin; the off step inverts every pin
    task automatic run_case(input logic [4:0] sel, input logic asg, input logic [7:0] mask,
                            input logic [2:0] m_on, input logic [2:0] m_off);
        logic [7:0] p;
        p = asg ? mask : 8'h00;
        set_cfg(sel, asg);
        pins(p, !asg);
        mode_is(m_on, sel == SMSO_SEL_SPD_ZC, sel == SMSO_SEL_POS_INH);
        pins(~p, asg);
        mode_is(m_off, 1'b0, 1'b0);
    endtask : run_case

    //--------------------------------------------------------------------------------
    // tests
    //--------------------------------------------------------------------------------
    initial
    begin
        logic w, r, e;
        {main_power_ok, hw_base_block, alarm_active, warning_active} = 4'h8;
        {absolute_data_request, absolute_encoder_used} = 2'h0;
        control_mode_selection = SMSO_SEL_SPD_POS;
        input_assignment_mode = SMSO_ASSIGN_PARAM;
        mode_switch_pin_sel = 3'h5;
        zero_clamp_pin_sel = 3'h2;
        pulse_inhibit_pin_sel = 3'h6;
        zero_clamp_param_a = 4'h1;
        zero_clamp_param_b = 16'h0100;
        speed_command_abs = 16'h0080;
        output_assignment_1 = SMSO_DEFAULT_OUT_1;
        output_assignment_2 = SMSO_DEFAULT_OUT_2;
        output_assignment_3 = SMSO_DEFAULT_OUT_3;
        repeat (8) @(negedge clk_sys);
        mode_is(SMSO_MODE_OTHER, 1'b0, 1'b0);
        check("out_pin", 16'(out_pin), 16'h0000);
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        settle();
        $display("test reset done");
        for (int a = 0; a < 2; a++)
        begin
            run_case(SMSO_SEL_SPD_POS, 1'(a), 8'h20, SMSO_MODE_SPEED, SMSO_MODE_POSITION);
            run_case(SMSO_SEL_TRQ_POS, 1'(a), 8'h20, SMSO_MODE_TORQUE, SMSO_MODE_POSITION);
            run_case(SMSO_SEL_SPD_TRQ, 1'(a), 8'h20, SMSO_MODE_SPEED, SMSO_MODE_TORQUE);
            run_case(SMSO_SEL_SPD_ZC, 1'(a), 8'h04, SMSO_MODE_SPEED_ZC, SMSO_MODE_SPEED);
            run_case(SMSO_SEL_POS_INH, 1'(a), 8'h40, SMSO_MODE_POS_INH, SMSO_MODE_POSITION);
        end
        set_cfg(5'h06, SMSO_ASSIGN_FIXED);
        settle();
        mode_is(SMSO_MODE_OTHER, 1'b0, 1'b0);
        $display("test mode table done");
        // clamping needs the enable and a speed strictly under the level
        set_cfg(SMSO_SEL_SPD_ZC, SMSO_ASSIGN_FIXED);
        pins(8'h00, 1'b1);
        @(negedge clk_sys);
        speed_command_abs = zero_clamp_param_b;
        settle();
        mode_is(SMSO_MODE_SPEED_ZC, 1'b0, 1'b0);
        @(negedge clk_sys);
        speed_command_abs = 16'h00FF;
        zero_clamp_param_a = SMSO_ZC_DISABLED;
        settle();
        mode_is(SMSO_MODE_SPEED_ZC, 1'b0, 1'b0);
        @(negedge clk_sys);
        zero_clamp_param_a = 4'h1;
        settle();
        mode_is(SMSO_MODE_SPEED_ZC, 1'b1, 1'b0);
        $display("test zero clamp done");
        set_cfg(SMSO_SEL_SPD_POS, SMSO_ASSIGN_FIXED);
        pins(8'h00, 1'b0);
        smso_host_model_i.put_pins(8'h00, 1'b1);
        repeat (2) @(negedge clk_sys);
        check("active_mode early", 16'(active_mode), 16'(SMSO_MODE_POSITION));
        @(negedge clk_sys);
        check("active_mode on time", 16'(active_mode), 16'(SMSO_MODE_SPEED));
        $display("test latency done");
        for (int v = 0; v < 32; v++)
        begin
            @(negedge clk_sys);
            {main_power_ok, hw_base_block, alarm_active, absolute_encoder_used, absolute_data_request} = 5'(v);
            settle();
            e = main_power_ok && !hw_base_block && !alarm_active && (!absolute_encoder_used || absolute_data_request);
            check("servo_ready", 16'(servo_ready), 16'(e));
            check("out_pin", 16'(out_pin), {15'h0000, e});
        end
        // the last code of the sweep blocks ready; the host needs ready to count its wait
        @(negedge clk_sys);
        {main_power_ok, hw_base_block, alarm_active, absolute_encoder_used, absolute_data_request} = 5'h10;
        for (int t = 0; t < 100 && !motion_ok; t++)
            @(negedge clk_sys);
        check("motion_ok", 16'(motion_ok), 16'h0001);
        $display("test servo ready done");
        for (int k = 0; k < 8; k++)
        begin
            w = k[0];
            r = k[1];
            @(negedge clk_sys);
            warning_active = w;
            main_power_ok = r;
            output_assignment_1 = k[2] ? SMSO_CODE_WARN_INV : SMSO_CODE_READY;
            output_assignment_2 = k[2] ? SMSO_CODE_READY : SMSO_CODE_WARN;
            output_assignment_3 = k[2] ? SMSO_CODE_WARN : SMSO_CODE_WARN_INV;
            settle();
            check("warning_out", 16'(warning_out), 16'(w));
            check("out_pin", 16'(out_pin), k[2] ? {13'h0000, w, r, !w} : {13'h0000, !w, w, r});
        end
        @(negedge clk_sys);
        {output_assignment_1, output_assignment_2, output_assignment_3} = {3{SMSO_CODE_UNUSED}};
        settle();
        check("out_pin", 16'(out_pin), 16'h0000);
        $display("test output slots done");
        complete_run();
    end

    // whole run is a few hundred cycles; this margin only catches a hang
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
endmodule : smso_mode_status_tb_top
